// ---- verilog/board_ctl_pkg.sv ----
// constants and types of the board control register bank
package board_ctl_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] MAIN_CONTROL_OFS = 16'h2000;
	localparam logic [15:0] LOOPBACK_LINK_CONTROL_OFS = 16'h2004;
	localparam logic [15:0] LINE_DIRECTION_A_OFS = 16'h2008;
	localparam logic [15:0] LINE_DIRECTION_B_OFS = 16'h200c;
	localparam logic [15:0] LINE_TERMINATION_A_OFS = 16'h2010;
	localparam logic [15:0] LINE_TERMINATION_B_OFS = 16'h2014;
	localparam logic [15:0] LINE_DATA_A_OFS = 16'h2018;
	localparam logic [15:0] LINE_DATA_B_OFS = 16'h201c;
	localparam logic [15:0] RX_PORT_BASE_OFS = 16'h2020;
	localparam logic [15:0] RX_PORT_STEP = 16'h0004;

	// ---------------------------------------------------------------
	// main control field positions
	// ---------------------------------------------------------------
	localparam int ID_LSB = 24;
	localparam int LED_LSB = 24;
	localparam int INT_LINE_BIT = 23;
	localparam int INT_STAT_BIT = 22;
	localparam int FORCE_INT_BIT = 21;
	localparam int INT_EN_BIT = 20;
	localparam int FLAG_LOAD_BIT = 19;
	localparam int FIFO_CLEAR_BIT = 18;
	localparam int SYNTH_EN_BIT = 17;
	localparam int UPPER_LSB = 9;
	localparam int SDA_BIT = 8;
	localparam int SCL_LSB = 0;

	// ---------------------------------------------------------------
	// loop-back and link field positions
	// ---------------------------------------------------------------
	localparam int PEER_SENSE_BIT = 20;
	localparam int PEER_DIR_BIT = 17;
	localparam int PEER_VAL_BIT = 16;
	localparam int TX_GO_LSB = 8;
	localparam int RX_GO_LSB = 0;

	// ---------------------------------------------------------------
	// sizes, reset values and fifo flag defaults
	// ---------------------------------------------------------------
	localparam int CHANNELS = 8;
	localparam int HALF_LINES = 20;
	localparam int LINES = 40;
	localparam logic [7:0] DESIGN_ID_DEFAULT = 8'h5a; // arbitrary value
	localparam logic [39:0] LINE_RESET = 40'h00_0000_0000;
	localparam logic [11:0] ALMOST_EMPTY_LEVEL_DEFAULT = 12'h007;
	localparam int FLAG_WIDTH = 12;

	// ---------------------------------------------------------------
	// state of the register bank
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] led;
		logic force_int;
		logic int_en;
		logic local_int;
		logic flag_load;
		logic fifo_clear;
		logic synth_en;
		logic [7:0] upper;
		logic sda_bit;
		logic [7:0] scl;
		logic peer_dir;
		logic peer_val;
		logic [7:0] tx_go;
		logic [7:0] rx_go;
		logic [39:0] dir;
		logic [39:0] term;
		logic [39:0] io;
		logic [31:0] rdata;
		logic rvalid;
		logic [7:0] move;
		logic [7:0] port_wr;
		logic [7:0] port_data;
	} state_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} bus_req_t;

	// differential line pins
	typedef struct packed {
		logic [39:0] value;
		logic [39:0] oe;
		logic [39:0] term;
	} line_pins_t;

endpackage

// ---- verilog/board_control_register_bank.sv ----
// control and status register bank of the reconfigurable board user logic
//
// Summary of operation
// - bits 27-24 write-only, one lights LED
// - bits 31-24 read back design identifier
// - bit 23 reads active-low interrupt line
// - bit 22 reads interrupt status, high
// - interrupt when force and enable set
// - bit 20 master enable, resets off
// - bit 18 holds receive FIFOs reset
// - bit 19 steers port writes to flags
// - offsets 12 bits, low byte first
// - each receive FIFO own write address
// - serial data low only when enabled, zero
// - bit 8 reads actual serial data line
// - bits 7-0 drive eight serial clocks
// - bits 16-9 drive synthesizer upper selects
// - bits 15-8 tx go, 7-0 rx go
// - mover runs while tx nonempty, rx notfull, not in clear or flag load
// - link driven from bit 16 when 17
// - bit 20 reads sampled link line
// - forty direction bits, reset to receive
// - forty termination bits, reset unterminated
// - line driven only when direction transmits
// - data read returns actual line levels
`timescale 1ns/1ps

module board_control_register_bank
#(
	parameter logic [7:0] DESIGN_ID = board_ctl_pkg::DESIGN_ID_DEFAULT
)
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire board_ctl_pkg::bus_req_t bus_i,
	output logic [31:0] bus_rdata_o,
	output logic bus_rvalid_o,
	output logic [3:0] led_on_o,
	output logic [3:0] led_n_o,
	output logic local_int_o,
	output logic lint_n_o,
	output logic rx_fifo_clear_o,
	output logic rx_flag_load_o,
	output logic [7:0] rx_port_wr_o,
	output logic [7:0] rx_port_data_o,
	output logic synth_en_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [7:0] scl_o,
	output logic [7:0] synth_upper_select_o,
	input wire logic [7:0] tx_empty_i,
	input wire logic [7:0] rx_full_i,
	output logic [7:0] tx_mover_rd_o,
	output logic [7:0] rx_mover_wr_o,
	input wire logic peer_i,
	output logic peer_o,
	output logic peer_oe_o,
	input wire logic [39:0] line_i,
	output board_ctl_pkg::line_pins_t line_o
);
	import board_ctl_pkg::*;

	state_t s_q;
	state_t s_d;

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------

	// address match for one register
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// upper half of a forty bit field
	function automatic logic [31:0] upper20(input logic [39:0] v);
		upper20 = {12'h000, v[39:20]};
	endfunction

	// lower half of a forty bit field
	function automatic logic [31:0] lower20(input logic [39:0] v);
		lower20 = {12'h000, v[19:0]};
	endfunction

	logic [31:0] main_rd;
	logic [31:0] link_rd;
	logic [7:0] port_hit;

	// ---------------------------------------------------------------
	// read views
	// ---------------------------------------------------------------

	// main control read value
	always_comb
	begin
		main_rd = 32'h0000_0000;
		main_rd[ID_LSB +: 8] = DESIGN_ID;
		main_rd[INT_LINE_BIT] = ~s_q.local_int;
		main_rd[INT_STAT_BIT] = s_q.local_int;
		main_rd[FORCE_INT_BIT] = s_q.force_int;
		main_rd[INT_EN_BIT] = s_q.int_en;
		main_rd[FLAG_LOAD_BIT] = s_q.flag_load;
		main_rd[FIFO_CLEAR_BIT] = s_q.fifo_clear;
		main_rd[SYNTH_EN_BIT] = s_q.synth_en;
		main_rd[UPPER_LSB +: 8] = s_q.upper;
		main_rd[SDA_BIT] = sda_i;
		main_rd[SCL_LSB +: 8] = s_q.scl;
	end

	// link control read value
	always_comb
	begin
		link_rd = 32'h0000_0000;
		link_rd[PEER_SENSE_BIT] = peer_i;
		link_rd[PEER_DIR_BIT] = s_q.peer_dir;
		link_rd[PEER_VAL_BIT] = s_q.peer_val;
		link_rd[TX_GO_LSB +: 8] = s_q.tx_go;
		link_rd[RX_GO_LSB +: 8] = s_q.rx_go;
	end

	// one write address per receive fifo
	always_comb
	begin
		for (int n = 0; n < CHANNELS; n++)
		begin
			port_hit[n] = hit(bus_i.addr, RX_PORT_BASE_OFS + RX_PORT_STEP * 16'(n));
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.port_wr = 8'h00;
		if (bus_i.wr)
		begin
			if (hit(bus_i.addr, MAIN_CONTROL_OFS))
			begin
				s_d.led = bus_i.wdata[LED_LSB +: 4];
				s_d.force_int = bus_i.wdata[FORCE_INT_BIT];
				s_d.int_en = bus_i.wdata[INT_EN_BIT];
				s_d.flag_load = bus_i.wdata[FLAG_LOAD_BIT];
				s_d.fifo_clear = bus_i.wdata[FIFO_CLEAR_BIT];
				s_d.synth_en = bus_i.wdata[SYNTH_EN_BIT];
				s_d.upper = bus_i.wdata[UPPER_LSB +: 8];
				s_d.sda_bit = bus_i.wdata[SDA_BIT];
				s_d.scl = bus_i.wdata[SCL_LSB +: 8];
			end
			if (hit(bus_i.addr, LOOPBACK_LINK_CONTROL_OFS))
			begin
				s_d.peer_dir = bus_i.wdata[PEER_DIR_BIT];
				s_d.peer_val = bus_i.wdata[PEER_VAL_BIT];
				s_d.tx_go = bus_i.wdata[TX_GO_LSB +: 8];
				s_d.rx_go = bus_i.wdata[RX_GO_LSB +: 8];
			end
			if (hit(bus_i.addr, LINE_DIRECTION_A_OFS))
				s_d.dir[39:20] = bus_i.wdata[19:0];
			if (hit(bus_i.addr, LINE_DIRECTION_B_OFS))
				s_d.dir[19:0] = bus_i.wdata[19:0];
			if (hit(bus_i.addr, LINE_TERMINATION_A_OFS))
				s_d.term[39:20] = bus_i.wdata[19:0];
			if (hit(bus_i.addr, LINE_TERMINATION_B_OFS))
				s_d.term[19:0] = bus_i.wdata[19:0];
			if (hit(bus_i.addr, LINE_DATA_A_OFS))
				s_d.io[39:20] = bus_i.wdata[19:0];
			if (hit(bus_i.addr, LINE_DATA_B_OFS))
				s_d.io[19:0] = bus_i.wdata[19:0];
			// offset bytes pass in write order
			s_d.port_wr = port_hit;
			if (|port_hit)
				s_d.port_data = bus_i.wdata[7:0];
		end
		s_d.local_int = s_d.force_int & s_d.int_en;
		// read data only on read decode
		if (bus_i.rd)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = 32'h0000_0000;
			if (hit(bus_i.addr, MAIN_CONTROL_OFS))
				s_d.rdata = main_rd;
			if (hit(bus_i.addr, LOOPBACK_LINK_CONTROL_OFS))
				s_d.rdata = link_rd;
			if (hit(bus_i.addr, LINE_DIRECTION_A_OFS))
				s_d.rdata = upper20(s_q.dir);
			if (hit(bus_i.addr, LINE_DIRECTION_B_OFS))
				s_d.rdata = lower20(s_q.dir);
			if (hit(bus_i.addr, LINE_TERMINATION_A_OFS))
				s_d.rdata = upper20(s_q.term);
			if (hit(bus_i.addr, LINE_TERMINATION_B_OFS))
				s_d.rdata = lower20(s_q.term);
			if (hit(bus_i.addr, LINE_DATA_A_OFS))
				s_d.rdata = upper20(line_i);
			if (hit(bus_i.addr, LINE_DATA_B_OFS))
				s_d.rdata = lower20(line_i);
		end
		// move one word every other cycle while source has data and sink room, not during clear or flag load
		for (int n = 0; n < CHANNELS; n++)
		begin
			s_d.move[n] = s_q.tx_go[n] & s_q.rx_go[n] & ~tx_empty_i[n] & ~rx_full_i[n]
				& ~s_q.move[n] & ~s_q.fifo_clear & ~s_q.flag_load;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------

	// all control bits clear at reset
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_q <= '0;
			s_q.dir <= LINE_RESET;
			s_q.term <= LINE_RESET;
			s_q.io <= LINE_RESET;
		end
		else
			s_q <= s_d;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------

	// bus answer
	assign bus_rdata_o = s_q.rdata;
	assign bus_rvalid_o = s_q.rvalid;

	// leds lit by ones, low side switched
	assign led_on_o = s_q.led;
	assign led_n_o = ~s_q.led;

	// interrupt lines
	assign local_int_o = s_q.local_int;
	assign lint_n_o = ~s_q.local_int;

	assign rx_fifo_clear_o = s_q.fifo_clear;
	assign rx_flag_load_o = s_q.flag_load;
	assign rx_port_wr_o = s_q.port_wr;
	assign rx_port_data_o = s_q.port_data;

	// serial data pulled low or released
	assign synth_en_o = s_q.synth_en;
	assign sda_o = 1'b0;
	assign sda_oe_o = s_q.synth_en & ~s_q.sda_bit;
	assign scl_o = s_q.scl;
	assign synth_upper_select_o = s_q.upper;

	// loop-back mover strobes
	assign tx_mover_rd_o = s_q.move;
	assign rx_mover_wr_o = s_q.move;

	assign peer_o = s_q.peer_val;
	assign peer_oe_o = s_q.peer_dir;

	assign line_o.value = s_q.io;
	assign line_o.oe = s_q.dir;
	assign line_o.term = s_q.term;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	// interrupt and main control checks
	int_follows_a: assert property (bus_i.wr && hit(bus_i.addr, MAIN_CONTROL_OFS)
		|=> local_int_o == ($past(bus_i.wdata[FORCE_INT_BIT]) && $past(bus_i.wdata[INT_EN_BIT])))
		else $error("interrupt does not follow force and enable");
	int_line_a: assert property (lint_n_o == !(s_q.force_int && s_q.int_en))
		else $error("interrupt line not inverse of status");
	led_write_a: assert property (bus_i.wr && hit(bus_i.addr, MAIN_CONTROL_OFS)
		|=> led_on_o == $past(bus_i.wdata[27:24]))
		else $error("led bits not taken");
	id_read_a: assert property (bus_i.rd && hit(bus_i.addr, MAIN_CONTROL_OFS)
		|=> bus_rvalid_o && bus_rdata_o[31:24] == DESIGN_ID)
		else $error("identifier not read back");
	fifo_clear_a: assert property (bus_i.wr && hit(bus_i.addr, MAIN_CONTROL_OFS)
		|=> rx_fifo_clear_o == $past(bus_i.wdata[FIFO_CLEAR_BIT]))
		else $error("fifo clear bit not taken");

	// serial, link, mover, line pin, read strobe and port write checks
	sda_drive_a: assert property (sda_oe_o |-> synth_en_o && !sda_o)
		else $error("serial data driven while disabled");
	sda_read_a: assert property (bus_i.rd && hit(bus_i.addr, MAIN_CONTROL_OFS)
		|=> bus_rdata_o[SDA_BIT] == $past(sda_i))
		else $error("serial data read not live");
	peer_sense_a: assert property (bus_i.rd && hit(bus_i.addr, LOOPBACK_LINK_CONTROL_OFS)
		|=> bus_rdata_o[PEER_SENSE_BIT] == $past(peer_i))
		else $error("link sense not sampled");
	peer_drive_a: assert property (bus_i.wr && hit(bus_i.addr, LOOPBACK_LINK_CONTROL_OFS)
		|=> peer_oe_o == $past(bus_i.wdata[PEER_DIR_BIT]) && peer_o == $past(bus_i.wdata[PEER_VAL_BIT]))
		else $error("link drive not taken");
	mover_guard_a: assert property (|rx_mover_wr_o |->
		($past(s_q.tx_go & s_q.rx_go & ~tx_empty_i & ~rx_full_i) & rx_mover_wr_o) == rx_mover_wr_o)
		else $error("mover ran without room or data");
	line_read_a: assert property (bus_i.rd && hit(bus_i.addr, LINE_DATA_B_OFS)
		|=> bus_rdata_o == {12'h000, $past(line_i[19:0])})
		else $error("line data read not from pins");
	dir_oe_a: assert property (bus_i.wr && hit(bus_i.addr, LINE_DIRECTION_A_OFS)
		|=> line_o.oe[39:20] == $past(bus_i.wdata[19:0]))
		else $error("direction write lost");
	term_write_a: assert property (bus_i.wr && hit(bus_i.addr, LINE_TERMINATION_B_OFS)
		|=> line_o.term[19:0] == $past(bus_i.wdata[19:0]))
		else $error("termination write lost");
	read_strobe_a: assert property (bus_rvalid_o |-> $past(bus_i.rd))
		else $error("read answer without request");
	port_wr_a: assert property (bus_i.wr && port_hit[3] |=> rx_port_wr_o == 8'h08)
		else $error("port write reached wrong fifo");

	// scenarios worth reaching
	int_raised_c: cover property (bus_i.wr ##1 local_int_o);
	mover_run_c: cover property (|rx_mover_wr_o ##2 |rx_mover_wr_o);
	flag_write_c: cover property (rx_flag_load_o && |rx_port_wr_o ##2 rx_flag_load_o && |rx_port_wr_o);
	link_read_c: cover property (bus_i.rd && hit(bus_i.addr, LOOPBACK_LINK_CONTROL_OFS) ##1 bus_rdata_o[PEER_SENSE_BIT]);

endmodule

// ---- tb/host_bus_model.sv ----
// host-side master that issues single register reads and writes
`timescale 1ns/1ps
module host_bus_model
(
	input wire logic mclk_i,
	input wire logic [31:0] rdata_i,
	input wire logic rvalid_i,
	output board_ctl_pkg::bus_req_t bus_o
);
	import board_ctl_pkg::*;

	initial bus_o = '0;

	// write strobe held across one taking edge, data scrambled after
	// decode strobes
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		bus_o.addr = a;
		bus_o.wdata = d;
		bus_o.wr = 1'b1;
		@(negedge mclk_i);
		bus_o.wr = 1'b0;
		bus_o.wdata = ~d;
	endtask

	// read strobe for one edge, answer taken while rvalid stands
	// decode strobes
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge mclk_i);
		bus_o.addr = a;
		bus_o.rd = 1'b1;
		@(negedge mclk_i);
		bus_o.rd = 1'b0;
		d = (rvalid_i === 1'b1) ? rdata_i : 'x;
	endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the board control register bank
`timescale 1ns/1ps
module testbench;
	import board_ctl_pkg::*;

	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] tx_empty_i = 8'hff;
	logic [7:0] rx_full_i = 8'h00;
	logic ext_peer = 1'b1;
	logic ext_sda_low = 1'b0;
	logic [39:0] ext_line = 40'h55555_55555;
	bus_req_t bus;
	logic [31:0] rdata;
	logic rvalid, sda_o, sda_oe_o, peer_o, peer_oe_o, synth_en_o;
	logic [3:0] led_on_o, led_n_o;
	logic local_int_o, lint_n_o, fclr, fload;
	logic [7:0] pwr, pdat, scl_o, upper, mrd, mwr;
	line_pins_t line_o;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] d;

	// wire levels: pull-up on serial data, far side elsewhere
	wire sda_w = (sda_oe_o | ext_sda_low) ? 1'b0 : 1'b1;
	wire peer_w = peer_oe_o ? peer_o : ext_peer;
	wire [39:0] line_w = (line_o.value & line_o.oe) | (ext_line & ~line_o.oe);

	initial forever #4 mclk_i = ~mclk_i;

	host_bus_model host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .bus_o(bus));

	board_control_register_bank uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus),
		.bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .led_on_o(led_on_o), .led_n_o(led_n_o),
		.local_int_o(local_int_o), .lint_n_o(lint_n_o), .rx_fifo_clear_o(fclr),
		.rx_flag_load_o(fload), .rx_port_wr_o(pwr), .rx_port_data_o(pdat),
		.synth_en_o(synth_en_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.scl_o(scl_o), .synth_upper_select_o(upper), .tx_empty_i(tx_empty_i),
		.rx_full_i(rx_full_i), .tx_mover_rd_o(mrd), .rx_mover_wr_o(mwr), .peer_i(peer_w),
		.peer_o(peer_o), .peer_oe_o(peer_oe_o), .line_i(line_w), .line_o(line_o));

	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		host.rd(a, d);
		chk("read data", {8'h0, e}, {8'h0, d});
	endtask

	task automatic t_reset();
		chk("line enable", 40'h0, line_o.oe);
		chk("line term", 40'h0, line_o.term);
		chk("line value", 40'h0, line_o.value);
		chk("led drive", 40'hf, led_n_o);
		rchk(MAIN_CONTROL_OFS, {DESIGN_ID_DEFAULT, 8'h80, 8'h01, 8'h00});
	endtask

	task automatic t_interrupt();
		host.wr(MAIN_CONTROL_OFS, 32'h0f30_0000);
		@(negedge mclk_i);
		chk("led on", 40'hf, led_on_o);
		chk("led drive", 40'h0, led_n_o);
		chk("int status", 40'h1, local_int_o);
		chk("int line", 40'h0, lint_n_o);
		rchk(MAIN_CONTROL_OFS, {DESIGN_ID_DEFAULT, 8'h70, 8'h01, 8'h00});
		host.wr(MAIN_CONTROL_OFS, 32'h0020_0000);
		@(negedge mclk_i);
		chk("int status", 40'h0, local_int_o);
		chk("int line", 40'h1, lint_n_o);
	endtask

	task automatic t_synth();
		host.wr(MAIN_CONTROL_OFS, 32'h0003_4a3c);
		chk("data pull", 40'h1, sda_oe_o);
		chk("serial clocks", 40'h3c, scl_o);
		chk("upper selects", 40'ha5, upper);
		chk("synth enable", 40'h1, synth_en_o);
		rchk(MAIN_CONTROL_OFS, 32'h5a83_4a3c);
		host.wr(MAIN_CONTROL_OFS, 32'h0003_4b3c);
		chk("data pull", 40'h0, sda_oe_o);
		rchk(MAIN_CONTROL_OFS, 32'h5a83_4b3c);
		chk("data level", 40'h0, sda_o);
		// far side pulls data low while the clock rises, written bit stays one
		ext_sda_low = 1'b1;
		host.wr(MAIN_CONTROL_OFS, 32'h0003_4b3d);
		chk("data pull", 40'h0, sda_oe_o);
		rchk(MAIN_CONTROL_OFS, 32'h5a83_4a3d);
		ext_sda_low = 1'b0;
		host.wr(MAIN_CONTROL_OFS, 32'h0000_0000);
		chk("data pull", 40'h0, sda_oe_o);
	endtask

	task automatic t_flags();
		logic [7:0] seq [4] = '{8'h07, 8'h00, 8'hff, 8'h0f};
		// flag load, clear pulse, offsets, then normal mode
		host.wr(MAIN_CONTROL_OFS, 32'h000c_0000);
		chk("fifo clear", 40'h1, fclr);
		chk("flag load", 40'h1, fload);
		host.wr(MAIN_CONTROL_OFS, 32'h0008_0000);
		chk("fifo clear", 40'h0, fclr);
		foreach (seq[i])
		begin
			host.wr(RX_PORT_BASE_OFS + RX_PORT_STEP, {24'h0, seq[i]});
			chk("port strobe", 40'h02, pwr);
			chk("port byte", {32'h0, seq[i]}, pdat);
		end
		host.wr(16'h203c, 32'h0000_0033);
		chk("port strobe", 40'h80, pwr);
		host.wr(MAIN_CONTROL_OFS, 32'h0000_0000);
		chk("flag load", 40'h0, fload);
		rchk(16'h2024, 32'h0);
	endtask

	task automatic t_link();
		host.wr(LOOPBACK_LINK_CONTROL_OFS, 32'h0002_0000);
		chk("link enable", 40'h1, peer_oe_o);
		rchk(LOOPBACK_LINK_CONTROL_OFS, 32'h0002_0000);
		host.wr(LOOPBACK_LINK_CONTROL_OFS, 32'h0001_0000);
		chk("link enable", 40'h0, peer_oe_o);
		rchk(LOOPBACK_LINK_CONTROL_OFS, 32'h0011_0000);
		ext_peer = 1'b0;
		host.wr(LOOPBACK_LINK_CONTROL_OFS, 32'h0003_0000);
		chk("link value", 40'h1, peer_o);
		rchk(LOOPBACK_LINK_CONTROL_OFS, 32'h0013_0000);
		ext_peer = 1'b1;
	endtask

	task automatic t_movers();
		int n;
		tx_empty_i = 8'hfe;
		host.wr(LOOPBACK_LINK_CONTROL_OFS, 32'h0000_0101);
		n = 0;
		repeat (8)
		begin
			@(negedge mclk_i);
			n += mrd[0];
			chk("mover pair", {32'h0, mrd}, {32'h0, mwr & 8'h01});
		end
		chk("moves", 40'd4, 40'(n));
		rx_full_i = 8'h01;
		repeat (2) @(negedge mclk_i);
		n = 0;
		repeat (4)
		begin
			@(negedge mclk_i);
			n += mrd[0];
		end
		chk("moves", 40'd0, 40'(n));
		rx_full_i = 8'h00;
		tx_empty_i = 8'hff;
		n = 0;
		repeat (4)
		begin
			@(negedge mclk_i);
			n += mrd[0];
		end
		chk("moves", 40'd0, 40'(n));
	endtask

	task automatic t_lines();
		host.wr(LINE_DIRECTION_A_OFS, 32'h000f_ffff);
		host.wr(LINE_TERMINATION_B_OFS, 32'h0000_f0f0);
		host.wr(LINE_DATA_A_OFS, 32'h0001_2345);
		host.wr(LINE_DATA_B_OFS, 32'h0006_789a);
		chk("line enable", 40'hfffff_00000, line_o.oe);
		chk("line term", 40'h00000_0f0f0, line_o.term);
		chk("line value", 40'h12345_6789a, line_o.value);
		rchk(LINE_DATA_A_OFS, 32'h0001_2345);
		rchk(LINE_DATA_B_OFS, 32'h0005_5555);
		rchk(LINE_DIRECTION_A_OFS, 32'h000f_ffff);
		rchk(16'h2100, 32'h0);
	endtask

	task automatic t_rereset();
		nrst_i = 1'b0;
		@(negedge mclk_i);
		chk("line enable", 40'h0, line_o.oe);
		chk("line term", 40'h0, line_o.term);
		chk("link enable", 40'h0, peer_oe_o);
		nrst_i = 1'b1;
		rchk(LINE_DIRECTION_A_OFS, 32'h0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// run-length ceiling
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	initial
	begin
		repeat (4) @(negedge mclk_i);
		nrst_i = 1'b1;
		t_reset();
		t_interrupt();
		t_synth();
		t_flags();
		t_link();
		t_movers();
		t_lines();
		t_rereset();
		report_and_stop();
	end
endmodule
